/* bench/dual_serial_line_strap_config_tb_top.sv */
// Self-checking bench for the dual line strap configuration block.
`timescale 1ns/1ps
module dual_serial_line_strap_config_tb_top
  import serial_strap_pkg::*;
;
  typedef struct {logic [31:0] exp; logic [31:0] msk;} note_s;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0][2:0] strap_rate = {3'h6, 3'h7};
  logic [7:0] strap_vsel = 8'hE4;
  logic vec_chan_i = 1'b0;
  logic [1:0][6:0] tx_data_i = 14'h0000;
  logic [1:0] bad = 2'h0;
  logic [1:0] line_even = 2'h1;
  logic [1:0] rx_check, rx_parity, tx_parity_o, parity_err_o;
  logic [1:0][6:0] rx_data;
  logic [31:0] rdata_o;
  logic [7:3] vector_o;
  logic [1:0] baud16_en_o, bit_en_o, char8_o, two_stop_o, even_par_o;
  logic refresh_en_o, pump_en_o, irq_o, rd_q = 1'b0;
  logic [1:0] perr_seen = 2'h0;
  logic [7:0] rnd = 8'h2E;
  note_s notes[$];
  note_s cur;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  serial_strap_cfg #(.REFRESH_TICKS(4), .PUMP_TICKS(2)) DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .strap_rate_i(strap_rate), .strap_char8_i(2'h2),
    .strap_two_stop_i(2'h1), .strap_even_i(2'h1),
    .strap_vsel_i(strap_vsel), .vec_chan_i(vec_chan_i),
    .vector_o(vector_o), .baud16_en_o(baud16_en_o), .bit_en_o(bit_en_o),
    .char8_o(char8_o), .two_stop_o(two_stop_o), .even_par_o(even_par_o),
    .tx_data_i(tx_data_i), .tx_parity_o(tx_parity_o),
    .rx_check_i(rx_check), .rx_data_i(rx_data), .rx_parity_i(rx_parity),
    .parity_err_o(parity_err_o), .refresh_en_o(refresh_en_o),
    .pump_en_o(pump_en_o), .irq_o(irq_o));

  for (genvar g = 0; g < 2; g++) begin : line
    serial_far_end far (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .bit_en_i(bit_en_o[g]), .even_i(line_even[g]), .bad_i(bad[g]),
      .rx_check_o(rx_check[g]), .rx_data_o(rx_data[g]),
      .rx_parity_o(rx_parity[g]));
  end

  always #10 sys_clk_i = ~sys_clk_i;

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // Reads are judged one cycle after the strobe, the only cycle they stand.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
    if (rd_q) begin
      cur = notes.pop_front();
      check((rdata_o & cur.msk) === cur.exp, "read data");
    end
    rd_q <= rd_i;
    for (int i = 0; i < 2; i++) if (parity_err_o[i] === 1'b1) perr_seen[i] = 1;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  function automatic logic [7:3] vexp(input logic [7:0] s, input logic ch);
    logic [3:0] b;
    for (int i = 0; i < 4; i++) begin
      case (s[2*i +: 2])
        2'h0: b[i] = ~ch;
        2'h1: b[i] = ch;
        2'h2: b[i] = 1'b0;
        default: b[i] = 1'b1;
      endcase
    end
    return {b[3], b[3], b[2], b[1], b[0]};
  endfunction : vexp

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    notes.push_back('{e, m});
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask : rd_reg

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  // Waits for a bit pulse; a limit keeps a dead divider from hanging.
  task automatic wait_bit(input int ch);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (bit_en_o[ch] !== 1'b1 && n < 12000);
    check(n < 12000, "no bit pulse");
  endtask : wait_bit

  task automatic period(input int ch, input int r);
    longint e;
    int n;
    int b;
    e = ((longint'(16) << RATE_SHIFT[r]) * SYS_CLK_HZ) / MASTER_HZ;
    n = 0;
    b = 0;
    wait_bit(ch);
    do begin
      tick(1);
      n++;
      if (baud16_en_o[ch] === 1'b1) b++;
    end while (bit_en_o[ch] !== 1'b1 && n < 12000);
    check(n >= e - 2 && n <= e + 2 && b == 16, "bit period");
  endtask : period

  initial begin
    longint m;
    int rf;
    int pm;
    logic [7:0] sel;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    tick(2);
    check(char8_o === 2'h2 && two_stop_o === 2'h1, "format");
    check(even_par_o === 2'h1, "parity sense");
    rd_reg(OFS_CH0_CFG, 32'h37, 32'hFFFFFFFF);
    rd_reg(OFS_CH1_CFG, 32'h0E, 32'hFFFFFFFF);
    rd_reg(OFS_VEC_SEL, 32'hE4, 32'hFFFFFFFF);
    rd_reg(OFS_IRQ_MSK, 32'h0, 32'hFFFFFFFF);
    rd_reg(OFS_LIVE, 32'h1, 32'h1);
    rd_reg(8'h18, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      sel = {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
      wr_reg(OFS_VEC_SEL, {24'h0, sel});
      vec_chan_i <= c[2];
      tick(3);
      check(vector_o === vexp(sel, c[2]), "vector");
    end
    $display("test vector done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(OFS_CH0_CFG, {26'h0, i[0], 2'h0, 3'h7});
      line_even[0] <= i[0];
      rnd = lfsr(rnd);
      tx_data_i <= {~rnd[6:0], rnd[6:0]};
      tick(2);
      check(tx_parity_o[0] === (i[0] ? ^rnd[6:0] : ~^rnd[6:0]), "tx par");
      check(even_par_o[0] === i[0] && char8_o[0] === 1'b0, "cfg out");
    end
    $display("test parity done");
    perr_seen = 2'h0;
    for (int r = 7; r > 4; r--) begin
      wr_reg(OFS_CH0_CFG, {26'h0, 1'b1, 2'h0, 3'(r)});
      period(0, r);
    end
    period(1, 6);
    $display("test baud done");
    m = (2000 * longint'(MASTER_HZ)) / SYS_CLK_HZ;
    rf = 0;
    pm = 0;
    repeat (2000) begin
      tick(1);
      if (refresh_en_o === 1'b1) rf++;
      if (pump_en_o === 1'b1) pm++;
    end
    check(rf >= m / 4 - 2 && rf <= m / 4 + 2, "refresh rate");
    check(pm >= m / 2 - 2 && pm <= m / 2 + 2, "pump rate");
    check(perr_seen === 2'h0, "false parity error");
    $display("test refresh done");
    wait_bit(0);
    tick(2);
    check(irq_o === 1'b0, "irq masked");
    wr_reg(OFS_IRQ_MSK, 32'h4);
    bad <= 2'h3;
    perr_seen = 2'h0;
    do tick(1); while (perr_seen[0] !== 1'b1 && cyc < 59000);
    @(posedge sys_clk_i);
    bad <= 2'h2;
    tick(2);
    check(irq_o === 1'b1, "irq on error");
    rd_reg(OFS_IRQ_STS, 32'h4, 32'h4);
    wr_reg(OFS_IRQ_STS, 32'h4);
    tick(2);
    check(irq_o === 1'b0, "irq cleared");
    period(1, 6);
    check(perr_seen[1] === 1'b0, "eight bit error");
    wait_bit(0);
    wr_reg(OFS_IRQ_STS, 32'h1);
    wr_reg(OFS_IRQ_MSK, 32'h1);
    tick(2);
    check(irq_o === 1'b0, "irq before bit tick");
    wait_bit(0);
    tick(2);
    check(irq_o === 1'b1, "irq on bit tick");
    $display("test irq done");
    stop_test();
  end
endmodule : dual_serial_line_strap_config_tb_top

/* bench/serial_far_end.sv */
// Model of the serial equipment that sends characters to one line.
`timescale 1ns/1ps
module serial_far_end (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic bit_en_i,
  input wire logic even_i,
  input wire logic bad_i,
  output logic rx_check_o,
  output logic [6:0] rx_data_o,
  output logic rx_parity_o
);
  logic [6:0] cnt_reg;
  // Between characters the lines toggle; data and parity flip together, so parity still matches and only rx_check_o marks new data.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 7'h00;
      rx_check_o <= 1'b0;
      rx_data_o <= 7'h00;
      rx_parity_o <= 1'b0;
    end else begin
      rx_check_o <= bit_en_i;
      if (bit_en_i) begin
        cnt_reg <= cnt_reg + 7'h03;
        rx_data_o <= cnt_reg;
        rx_parity_o <= (even_i ? ^cnt_reg : ~^cnt_reg) ^ bad_i;
      end else begin
        rx_data_o <= ~rx_data_o;
        rx_parity_o <= ~rx_parity_o;
      end
    end
  end
endmodule : serial_far_end

/* src/master_tick_gen.sv */
// Master oscillator emulation and fixed dividers for baud, refresh and pump.
`timescale 1ns/1ps
module master_tick_gen
  import serial_strap_pkg::*;
#(
  parameter int REFRESH_TICKS = REFRESH_DIV,
  parameter int PUMP_TICKS = PUMP_DIV
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  output logic master_en_o,
  output logic [NUM_RATES-1:0] rate_en_o,
  output logic refresh_en_o,
  output logic pump_en_o
);

  typedef struct packed {
    logic [NCO_W-1:0] acc;
    logic [MDIV_W-1:0] mcnt;
    logic master;
    logic [NUM_RATES-1:0] rate;
    logic [15:0] rcnt;
    logic [15:0] pcnt;
    logic refresh;
    logic pump;
  } tick_s;

  tick_s tick_reg;
  tick_s tick_next;
  logic [NCO_W:0] sum;

  always_comb begin
    tick_next = tick_reg;
    tick_next.master = 1'b0;
    tick_next.rate = '0;
    tick_next.refresh = 1'b0;
    tick_next.pump = 1'b0;
    // The phase accumulator stands in for the 19.6608 MHz crystal.
    sum = {1'b0, tick_reg.acc} + {1'b0, NCO_STEP};
    if (sum >= {1'b0, NCO_MOD}) begin
      tick_next.acc = NCO_W'(sum - {1'b0, NCO_MOD});
      tick_next.master = 1'b1;
    end else begin
      tick_next.acc = NCO_W'(sum);
    end
    if (tick_reg.master) begin
      tick_next.mcnt = tick_reg.mcnt + 1'b1;
      // Each rate is an exact power-of-two division of the master.
      for (int i = 0; i < NUM_RATES; i++) begin
        tick_next.rate[i] = &(tick_reg.mcnt | ~MDIV_W'((1 << RATE_SHIFT[i]) - 1));
      end
      // Refresh and pump timing share the master tick.
      if (tick_reg.rcnt == 16'(REFRESH_TICKS - 1)) begin
        tick_next.rcnt = '0;
        tick_next.refresh = 1'b1;
      end else begin
        tick_next.rcnt = tick_reg.rcnt + 1'b1;
      end
      if (tick_reg.pcnt == 16'(PUMP_TICKS - 1)) begin
        tick_next.pcnt = '0;
        tick_next.pump = 1'b1;
      end else begin
        tick_next.pcnt = tick_reg.pcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  assign master_en_o = tick_reg.master;
  assign rate_en_o = tick_reg.rate;
  assign refresh_en_o = tick_reg.refresh;
  assign pump_en_o = tick_reg.pump;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // The master rate is below half the system clock.
  a_master_spacing: assert property (master_en_o |=> !master_en_o)
    else $error("master tick pulses back to back");

  // The slowest rate fires only where every faster rate fires as well.
  a_rates_nest: assert property (rate_en_o[0] |-> &rate_en_o)
    else $error("rate enables not nested");

  a_refresh_src: assert property (refresh_en_o |-> $past(master_en_o))
    else $error("refresh tick without master tick");

endmodule : master_tick_gen

/* src/serial_strap_cfg.sv */
// Strap-loaded configuration, baud selection and vector logic of two lines.
//
// How it works
// - Line 0 uses one selected 16x clock for both directions.
// - Line 1 has its own 16x clock, chosen independently from same set.
// - Eight rates: 150, 300, 1200, 2400, 4800, 9600, 19200, 38400 baud.
// - A 19.6608 MHz master oscillator is the timing source.
// - The master also times memory refresh and the negative voltage pump.
// - Vector bits 3, 4, 5 each pick channel-following, inverse, zero or one.
// - Following source is one for channel 0, zero for channel 1; inverse opposite.
// - Per line: low selects seven bits with parity, high eight without.
// - Per line: low selects one stop bit, high selects two.
// - Seven-bit format: low select odd parity, high even; ignored for eight.
`timescale 1ns/1ps
module serial_strap_cfg
  import serial_strap_pkg::*;
#(
  parameter int REFRESH_TICKS = REFRESH_DIV,
  parameter int PUMP_TICKS = PUMP_DIV
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [1:0][2:0] strap_rate_i,
  input wire logic [1:0] strap_char8_i,
  input wire logic [1:0] strap_two_stop_i,
  input wire logic [1:0] strap_even_i,
  input wire logic [7:0] strap_vsel_i,
  input wire logic vec_chan_i,
  output logic [7:3] vector_o,
  output logic [1:0] baud16_en_o,
  output logic [1:0] bit_en_o,
  output logic [1:0] char8_o,
  output logic [1:0] two_stop_o,
  output logic [1:0] even_par_o,
  input wire logic [1:0][6:0] tx_data_i,
  output logic [1:0] tx_parity_o,
  input wire logic [1:0] rx_check_i,
  input wire logic [1:0][6:0] rx_data_i,
  input wire logic [1:0] rx_parity_i,
  output logic [1:0] parity_err_o,
  output logic refresh_en_o,
  output logic pump_en_o,
  output logic irq_o
);

  typedef struct packed {
    logic strap_done;
    logic [1:0][CFG_W-1:0] cfg;
    logic [7:0] vsel;
    logic [IRQ_W-1:0] sts;
    logic [IRQ_W-1:0] msk;
    logic [31:0] rdata;
    logic [1:0] b16;
    logic [1:0][3:0] sub;
    logic [1:0] bit_en;
    logic [1:0] tx_par;
    logic [1:0] perr;
    logic [4:0] vec;
  } cfg_s;

  cfg_s st_reg;
  cfg_s st_next;
  logic master_en;
  logic [NUM_RATES-1:0] rate_en;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr;

  master_tick_gen #(
    .REFRESH_TICKS(REFRESH_TICKS),
    .PUMP_TICKS(PUMP_TICKS)
  ) u_ticks (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .master_en_o(master_en),
    .rate_en_o(rate_en),
    .refresh_en_o(refresh_en_o),
    .pump_en_o(pump_en_o)
  );

  // Parity bit over seven data bits; even makes the total count even.
  function automatic logic par_bit(input logic [6:0] d, input logic even);
    par_bit = even ? ^d : ~^d;
  endfunction : par_bit

  // One vector bit from its two-bit source select.
  function automatic logic vec_bit(input logic [1:0] sel, input logic ch1);
    vec_src_e src;
    src = vec_src_e'(sel);
    unique case (src)
      VEC_CH0: vec_bit = ~ch1;
      VEC_CH1: vec_bit = ch1;
      VEC_ZERO: vec_bit = 1'b0;
      VEC_ONE: vec_bit = 1'b1;
    endcase
  endfunction : vec_bit

  // Bit ticks and parity errors are the interrupt events, latched as status.
  // Both come from registers, so a status bit lags its pulse by one cycle.
  assign events = {st_reg.perr, st_reg.bit_en};

  always_comb begin
    st_next = st_reg;
    st_next.rdata = '0;
    st_next.bit_en = '0;
    st_next.perr = '0;
    clr = '0;

    // Straps are caught once, on the first edge after reset release.
    if (!st_reg.strap_done) begin
      st_next.strap_done = 1'b1;
      st_next.vsel = strap_vsel_i;
      for (int ch = 0; ch < 2; ch++) begin
        st_next.cfg[ch] = {strap_even_i[ch], strap_two_stop_i[ch],
                           strap_char8_i[ch], strap_rate_i[ch]};
      end
    end

    for (int ch = 0; ch < 2; ch++) begin
      // One 16x clock per line serves transmit and receive.
      st_next.b16[ch] = rate_en[st_reg.cfg[ch][CFG_RATE_LSB+:3]];
      if (st_reg.b16[ch]) begin
        st_next.sub[ch] = st_reg.sub[ch] + 1'b1;
        st_next.bit_en[ch] = (st_reg.sub[ch] == SUB_LAST);
      end
      // Parity follows the select; unused in eight-bit format.
      st_next.tx_par[ch] = par_bit(tx_data_i[ch], st_reg.cfg[ch][CFG_EVEN]);
      st_next.perr[ch] = rx_check_i[ch] && !st_reg.cfg[ch][CFG_CHAR8] &&
        (par_bit(rx_data_i[ch], st_reg.cfg[ch][CFG_EVEN]) != rx_parity_i[ch]);
    end

    // Vector bits 3 to 5, then bits 6 and 7 from one shared field.
    for (int b = 0; b < 3; b++) begin
      st_next.vec[b] = vec_bit(st_reg.vsel[2*b+:2], vec_chan_i);
    end
    st_next.vec[3] = vec_bit(st_reg.vsel[7:6], vec_chan_i);
    st_next.vec[4] = st_next.vec[3];

    if (wr_i) begin
      unique case (addr_i)
        OFS_CH0_CFG: st_next.cfg[0] = wdata_i[CFG_W-1:0];
        OFS_CH1_CFG: st_next.cfg[1] = wdata_i[CFG_W-1:0];
        OFS_VEC_SEL: st_next.vsel = wdata_i[7:0];
        OFS_IRQ_STS: clr = wdata_i[IRQ_W-1:0];
        OFS_IRQ_MSK: st_next.msk = wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
    // A new event beats a clear written in the same cycle.
    st_next.sts = (st_reg.sts & ~clr) | events;

    if (rd_i) begin
      unique case (addr_i)
        OFS_CH0_CFG: st_next.rdata = 32'(st_reg.cfg[0]);
        OFS_CH1_CFG: st_next.rdata = 32'(st_reg.cfg[1]);
        OFS_VEC_SEL: st_next.rdata = 32'(st_reg.vsel);
        OFS_IRQ_STS: st_next.rdata = 32'(st_reg.sts);
        OFS_IRQ_MSK: st_next.rdata = 32'(st_reg.msk);
        OFS_LIVE: st_next.rdata = 32'({st_reg.sub[1], st_reg.sub[0],
                                       st_reg.b16, st_reg.strap_done});
        default: st_next.rdata = '0;
      endcase
    end
  end

  // Reset loads constants only; straps are caught after release so that
  // the capture never depends on pin levels while reset is held.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{strap_done: 1'b0, cfg: {CFG_RST, CFG_RST},
                  vsel: VSEL_RST, msk: MSK_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign vector_o = st_reg.vec;
  assign baud16_en_o = st_reg.b16;
  assign bit_en_o = st_reg.bit_en;
  // Format and stop selects go straight to the shifters.
  assign char8_o = {st_reg.cfg[1][CFG_CHAR8], st_reg.cfg[0][CFG_CHAR8]};
  assign two_stop_o = {st_reg.cfg[1][CFG_TWO_STOP],
                       st_reg.cfg[0][CFG_TWO_STOP]};
  assign even_par_o = {st_reg.cfg[1][CFG_EVEN], st_reg.cfg[0][CFG_EVEN]};
  assign tx_parity_o = st_reg.tx_par;
  assign parity_err_o = st_reg.perr;
  assign irq_o = |(st_reg.sts & st_reg.msk);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cfg0_write;
    wr_i && addr_i == OFS_CH0_CFG && st_reg.strap_done;
  endsequence

  sequence s_vsel_quiet;
    !(wr_i && addr_i == OFS_VEC_SEL) && st_reg.strap_done;
  endsequence

  sequence s_cfg1_write;
    wr_i && addr_i == OFS_CH1_CFG && st_reg.strap_done;
  endsequence

  sequence s_line0_check;
    rx_check_i[0] && !st_reg.cfg[0][CFG_CHAR8];
  endsequence

  a_ch0_bit_tick: assert property (bit_en_o[0] |-> $past(baud16_en_o[0]))
    else $error("line 0 bit tick without 16x tick");

  a_ch1_rate_sel: assert property (baud16_en_o[1] |->
    $past(rate_en[st_reg.cfg[1][CFG_RATE_LSB+:3]]))
    else $error("line 1 16x tick not from selected rate");

  a_ch0_sixteen: assert property (bit_en_o[0] && st_reg.cfg[0][2:0] == 3'h7
    && $stable(st_reg.cfg[0]) |-> $past(st_reg.sub[0], 1) == SUB_LAST)
    else $error("bit tick not after sixteen 16x ticks");

  a_fast_rate: assert property (baud16_en_o[0] && $stable(st_reg.cfg[0])
    && st_reg.cfg[0][2:0] == 3'h7 |-> ##1 !baud16_en_o[0] [*8])
    else $error("38400 16x ticks spaced too closely");

  a_vec_follow: assert property (s_vsel_quiet ##0 (st_reg.vsel[1:0] == 2'h0)
    ##0 !vec_chan_i |=> vector_o[3])
    else $error("vector bit 3 not one for channel 0");

  a_vec_inverse: assert property (s_vsel_quiet ##0 (st_reg.vsel[3:2] == 2'h1)
    ##0 !vec_chan_i |=> !vector_o[4])
    else $error("vector bit 4 inverse source wrong");

  a_vec_top: assert property (s_vsel_quiet ##0 (st_reg.vsel[7:6] == 2'h3)
    |=> vector_o[7:6] == 2'b11)
    else $error("vector bits 6 and 7 not both one");

  a_format_write: assert property (s_cfg0_write |=>
    char8_o[0] == $past(wdata_i[CFG_CHAR8]))
    else $error("character format not taken");

  a_stop_write: assert property (s_cfg0_write |=>
    two_stop_o[0] == $past(wdata_i[CFG_TWO_STOP]))
    else $error("stop bit select not taken");

  a_odd_check: assert property (rx_check_i[0] && !st_reg.cfg[0][CFG_CHAR8]
    && !st_reg.cfg[0][CFG_EVEN] && ^{rx_data_i[0], rx_parity_i[0]}
    |=> !parity_err_o[0])
    else $error("odd parity flagged wrongly");

  a_eight_noerr: assert property (st_reg.cfg[1][CFG_CHAR8]
    |=> !parity_err_o[1])
    else $error("parity error in eight bit format");

  a_irq_sticky: assert property (bit_en_o[0] |=> st_reg.sts[IRQ_BIT0])
    else $error("bit event not latched");

  // Line 1 carries the bit tick, sixteen, format, stop and eight-bit no-error checks of line 0, not its odd and even parity checks; its divider is a separate copy.
  a_ch1_bit_tick: assert property (
    bit_en_o[1] |-> $past(baud16_en_o[1]))
    else $error("line 1 bit tick without 16x tick");

  a_ch0_rate_sel: assert property (
    baud16_en_o[0] |-> $past(rate_en[st_reg.cfg[0][CFG_RATE_LSB+:3]]))
    else $error("line 0 16x tick not from selected rate");

  a_ch1_sixteen: assert property (
    bit_en_o[1] |-> $past(st_reg.sub[1]) == SUB_LAST)
    else $error("line 1 bit tick not after sixteen 16x ticks");

  a_vec_ch1_sel: assert property (
    s_vsel_quiet ##0 (st_reg.vsel[1:0] == 2'h0) ##0 vec_chan_i
    |=> !vector_o[3])
    else $error("vector bit 3 not zero for channel 1");

  a_vec_one: assert property (
    s_vsel_quiet ##0 (st_reg.vsel[5:4] == 2'h3) |=> vector_o[5])
    else $error("vector bit 5 not held at one");

  a_vec_zero: assert property (
    s_vsel_quiet ##0 (st_reg.vsel[5:4] == 2'h2) |=> !vector_o[5])
    else $error("vector bit 5 not held at zero");

  a_vec_pair: assert property (
    vector_o[7] == vector_o[6])
    else $error("vector bits 6 and 7 differ");

  a_strap_vsel: assert property (
    !st_reg.strap_done && !wr_i |=> st_reg.vsel == $past(strap_vsel_i))
    else $error("vector selects not taken from straps");

  a_strap_load: assert property (
    !st_reg.strap_done && !wr_i |=> char8_o == $past(strap_char8_i))
    else $error("format not taken from straps");

  a_even_check: assert property (
    s_line0_check ##0 st_reg.cfg[0][CFG_EVEN]
    ##0 !(^{rx_data_i[0], rx_parity_i[0]}) |=> !parity_err_o[0])
    else $error("even parity flagged wrongly");

  a_odd_detect: assert property (
    s_line0_check ##0 !st_reg.cfg[0][CFG_EVEN]
    ##0 !(^{rx_data_i[0], rx_parity_i[0]}) |=> parity_err_o[0])
    else $error("odd parity error missed");

  a_eight_noerr0: assert property (
    st_reg.cfg[0][CFG_CHAR8] |=> !parity_err_o[0])
    else $error("parity error on line 0 in eight bit format");

  a_format_write1: assert property (
    s_cfg1_write |=> char8_o[1] == $past(wdata_i[CFG_CHAR8]))
    else $error("line 1 character format not taken");

  a_stop_write1: assert property (
    s_cfg1_write |=> two_stop_o[1] == $past(wdata_i[CFG_TWO_STOP]))
    else $error("line 1 stop bit select not taken");

  // The parity bit is made every cycle; the shifter uses it only when needed.
  a_tx_even: assert property (
    st_reg.cfg[0][CFG_EVEN] |=> tx_parity_o[0] == ^$past(tx_data_i[0]))
    else $error("even transmit parity wrong");

  a_tx_odd: assert property (
    !st_reg.cfg[0][CFG_EVEN] |=> tx_parity_o[0] == ~^$past(tx_data_i[0]))
    else $error("odd transmit parity wrong");

  a_perr_latch: assert property (
    parity_err_o[0] |=> st_reg.sts[IRQ_PERR0])
    else $error("parity error not latched");

  a_sts_clear: assert property (
    wr_i && addr_i == OFS_IRQ_STS && wdata_i[IRQ_BIT1] && !bit_en_o[1]
    |=> !st_reg.sts[IRQ_BIT1])
    else $error("status bit not cleared by writing one");

  // Read data must idle at zero so a stray sample never looks like a value.
  a_rdata_idle: assert property (
    !rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero without a read");

endmodule : serial_strap_cfg

/* src/serial_strap_pkg.sv */
// Shared constants and types for the dual serial line strap configuration.
package serial_strap_pkg;

  // System clock and master oscillator rates in hertz.
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned MASTER_HZ = 19_660_800;
  localparam int NCO_W = 27;
  localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(MASTER_HZ);
  localparam logic [NCO_W-1:0] NCO_MOD = NCO_W'(SYS_CLK_HZ);

  // Sixteen-times clocks per bit and the width of the master tick counter.
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SUB_LAST = 4'(OVERSAMPLE - 1);
  localparam int NUM_RATES = 8;
  localparam int MDIV_W = 13;

  // Master ticks per 16x clock are powers of two, listed as log2 values.
  // Index 0..7 selects 150, 300, 1200, 2400, 4800, 9600, 19200, 38400 baud.
  localparam int RATE_SHIFT [NUM_RATES] = '{13, 12, 10, 9, 8, 7, 6, 5};

  // Default dividers of the master tick for refresh and charge pump.
  localparam int REFRESH_DIV = 256;
  localparam int PUMP_DIV = 64;

  // Register byte offsets.
  localparam logic [7:0] OFS_CH0_CFG = 8'h00;
  localparam logic [7:0] OFS_CH1_CFG = 8'h04;
  localparam logic [7:0] OFS_VEC_SEL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h10;
  localparam logic [7:0] OFS_LIVE = 8'h14;

  // Channel configuration field positions.
  localparam int CFG_W = 6;
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_CHAR8 = 3;
  localparam int CFG_TWO_STOP = 4;
  localparam int CFG_EVEN = 5;

  // Interrupt status bit positions.
  localparam int IRQ_W = 4;
  localparam int IRQ_BIT0 = 0;
  localparam int IRQ_BIT1 = 1;
  localparam int IRQ_PERR0 = 2;
  localparam int IRQ_PERR1 = 3;

  // Reset values.
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
  localparam logic [7:0] VSEL_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MSK_RST = 4'h0;

  // Source of one interrupt vector bit.
  typedef enum logic [1:0] {
    VEC_CH0,
    VEC_CH1,
    VEC_ZERO,
    VEC_ONE
  } vec_src_e;

endpackage : serial_strap_pkg
